// ==== vasd_map.svh ====
`ifndef VASD_MAP_SVH
`define VASD_MAP_SVH
`define VASD_VA_BITS        64
`define VASD_MIN_VA_BITS    43
`define VASD_FRAME_BITS     32
`define VASD_LEVELS         3
`define VASD_SEG_BITS       2
`define VASD_PAGE_SHIFT_16K 14
`define VASD_PAGE_SHIFT_32K 15
`define VASD_SEG_DIRECT     2'h2
`define VASD_SEG_HIGH       2'h3
`define VASD_PTE_UWE_BIT    13
`define VASD_PAGE_SHIFT_MIN 13
`define VASD_PAGE_SHIFT_MAX 16
`define VASD_LEVEL_LESS     3
`define VASD_PA_MAX_8K      41
`define VASD_PA_MAX_16K     45
`define VASD_PA_MAX_32K     47
`define VASD_PA_MAX_64K     48
`endif

// ==== vasd_pkg.sv ====
`include "vasd_map.svh"
package vasd_pkg;
    typedef enum logic [1:0] {
        VASD_SEG_LOW_TYPE_UNUSED = 2'h0
    } vasd_dummy_type;

    typedef enum logic [1:0] {
        low_mapped_segment    = 2'h0,
        high_mapped_segment   = 2'h1,
        kernel_direct_segment = 2'h3
    } vasd_seg_type;

    typedef struct packed {
        logic        valid;
        logic [63:0] va;
        logic        user_mode;
        logic        is_store;
        logic        pte_valid;
        logic        user_write_enable;
    } vasd_req_type;

    typedef struct packed {
        logic         valid;
        logic         fault;
        vasd_seg_type seg;
        logic         translate;
        logic [63:0]  phys_addr;
        logic [15:0]  first_level_index;
        logic [15:0]  second_level_index;
        logic [15:0]  third_level_index;
        logic [15:0]  page_offset;
    } vasd_rsp_type;
endpackage : vasd_pkg

// ==== vasd_field_split.sv ====
`timescale 1ns/10ps
`include "vasd_map.svh"
module vasd_field_split
    import vasd_pkg::*;
#(
    parameter int PAGE_SHIFT = 13
) (
    input  wire logic [63:0] va,
    output logic      [15:0] first_level_index,
    output logic      [15:0] second_level_index,
    output logic      [15:0] third_level_index,
    output logic      [15:0] page_offset
);
    localparam int LEVEL_BITS = PAGE_SHIFT - `VASD_LEVEL_LESS;

    function automatic logic [15:0] field_at(input logic [63:0] a, input int lsb, input int w);
        logic [63:0] s;
        s = a >> lsb;
        field_at = s[15:0] & 16'((32'h0000_0001 << w) - 1);
    endfunction : field_at

    always_comb begin
        page_offset        = field_at(va, 0, PAGE_SHIFT);
        third_level_index  = field_at(va, PAGE_SHIFT, LEVEL_BITS);
        second_level_index = field_at(va, PAGE_SHIFT + LEVEL_BITS, LEVEL_BITS);
        first_level_index  = field_at(va, PAGE_SHIFT + 2 * LEVEL_BITS, LEVEL_BITS);
    end
endmodule : vasd_field_split

// ==== vasd_decode.sv ====
`timescale 1ns/10ps
`include "vasd_map.svh"
// Notes on behaviour
// - Every virtual address is a 64-bit unsigned byte address.
// - Implemented width is 43, 47, 51 or 55, set by page size.
// - Implemented width is never below 43 bits.
// - Bits 63 down to width must equal bit width minus one.
// - An address outside the valid range faults instead of completing.
// - Two bits below width pick low mapped, direct or high mapped segment.
// - Direct segment has fixed mapping and allows kernel access only.
// - Direct physical address is the low physical-width bits, zero above them, no lookup.
// - Page offset is 13 to 16 bits, pages of 8K to 64K.
// - Mapped address splits into three indices plus offset; upper bits sign-extend.
// - All three indices share one width, 10 to 13 bits.
// - Each level's entries fit in at most one page.
// - Frame number is 32 bits; widths grow with page size.
// - Physical width limit is 41, 45, 47 or 48 bits.
// - Physical width is at most virtual width minus two.
// - User store to mapped page without user write enable faults, even invalid.
module vasd_decode
    import vasd_pkg::*;
#(
    parameter int PAGE_SHIFT = `VASD_PAGE_SHIFT_MIN
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire vasd_req_type req,
    output vasd_rsp_type      rsp
);
    // Widths follow from page size alone
    localparam int LEVEL_BITS = PAGE_SHIFT - `VASD_LEVEL_LESS;
    localparam int VA_WIDTH   = PAGE_SHIFT + `VASD_LEVELS * LEVEL_BITS;
    localparam int PA_MAPPED  = PAGE_SHIFT + `VASD_FRAME_BITS;
    localparam int PA_DIRECT  = VA_WIDTH - `VASD_SEG_BITS;
    localparam int PA_WIDTH   = (PA_MAPPED < PA_DIRECT) ? PA_MAPPED : PA_DIRECT;

    // Expected physical limit per page size, to catch a bad width formula
    function automatic int pa_limit(input int shift);
        case (shift)
            `VASD_PAGE_SHIFT_MIN: pa_limit = `VASD_PA_MAX_8K;
            `VASD_PAGE_SHIFT_16K: pa_limit = `VASD_PA_MAX_16K;
            `VASD_PAGE_SHIFT_32K: pa_limit = `VASD_PA_MAX_32K;
            default:              pa_limit = `VASD_PA_MAX_64K;
        endcase
    endfunction : pa_limit

    initial begin
        if (PAGE_SHIFT < `VASD_PAGE_SHIFT_MIN || PAGE_SHIFT > `VASD_PAGE_SHIFT_MAX)
            $error("vasd_decode: page shift out of range");
        if (VA_WIDTH < `VASD_MIN_VA_BITS)
            $error("vasd_decode: virtual width too small");
        if (PA_WIDTH != pa_limit(PAGE_SHIFT))
            $error("vasd_decode: physical width off its limit");
    end

    vasd_rsp_type next_rsp;
    logic [15:0]  idx1;
    logic [15:0]  idx2;
    logic [15:0]  idx3;
    logic [15:0]  offs;

    vasd_field_split #(
        .PAGE_SHIFT (PAGE_SHIFT)
    ) u_split (
        .va                 (req.va),
        .first_level_index  (idx1),
        .second_level_index (idx2),
        .third_level_index  (idx3),
        .page_offset        (offs)
    );

    // Sign-extend from a given top bit; used for range check and relocation
    function automatic logic [63:0] sext_from(input logic [63:0] a, input int top);
        logic [63:0] m;
        m = 64'hFFFF_FFFF_FFFF_FFFF << (top + 1);
        sext_from = a[top] ? (a | m) : (a & ~m);
    endfunction : sext_from

    logic       canonical;
    logic [1:0] sel;
    logic       user_store_denied;
    logic       direct_denied;

    always_comb begin
        canonical = (sext_from(req.va, VA_WIDTH - 1) == req.va);
        sel       = req.va[VA_WIDTH - 1 -: `VASD_SEG_BITS];
        user_store_denied = req.user_mode && req.is_store && !req.user_write_enable;
        direct_denied     = req.user_mode;

        next_rsp           = '0;
        next_rsp.valid     = req.valid;
        next_rsp.first_level_index  = idx1;
        next_rsp.second_level_index = idx2;
        next_rsp.third_level_index  = idx3;
        next_rsp.page_offset        = offs;
        case (sel)
            `VASD_SEG_DIRECT: begin
                next_rsp.seg       = kernel_direct_segment;
                next_rsp.translate = 1'b0;
                // Relocation is fixed; bits above physical width are not kept
                next_rsp.phys_addr = sext_from(req.va, PA_DIRECT - 1)
                                     & ~(64'hFFFF_FFFF_FFFF_FFFF << PA_WIDTH);
                next_rsp.fault     = req.valid && (!canonical || direct_denied);
            end
            `VASD_SEG_HIGH: begin
                next_rsp.seg       = high_mapped_segment;
                next_rsp.translate = canonical;
                next_rsp.fault     = req.valid && (!canonical || user_store_denied);
            end
            default: begin
                next_rsp.seg       = low_mapped_segment;
                next_rsp.translate = canonical;
                next_rsp.fault     = req.valid && (!canonical || user_store_denied);
            end
        endcase
        if (!req.valid) begin
            next_rsp.translate = 1'b0;
        end
    end

    // One stage of registers keeps every output on a flip-flop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rsp <= '0;
        end else begin
            rsp <= next_rsp;
        end
    end

    chk_noncanon_fault: assert property (@(posedge clk) disable iff (!rst_n)
        (req.valid && !canonical) |=> (rsp.fault && !rsp.translate))
        else $error("non-canonical address did not fault");

    chk_user_direct: assert property (@(posedge clk) disable iff (!rst_n)
        (req.valid && req.user_mode && sel == `VASD_SEG_DIRECT) |=> rsp.fault)
        else $error("user access to direct segment did not fault");

    chk_direct_kernel_ok: assert property (@(posedge clk) disable iff (!rst_n)
        (req.valid && canonical && !req.user_mode && sel == `VASD_SEG_DIRECT)
        |=> (!rsp.fault && rsp.seg == kernel_direct_segment && !rsp.translate))
        else $error("kernel direct access mishandled");

    chk_direct_pa: assert property (@(posedge clk) disable iff (!rst_n)
        (req.valid && sel == `VASD_SEG_DIRECT)
        |=> rsp.phys_addr[PA_WIDTH - 1:0] == $past(req.va[PA_WIDTH - 1:0]))
        else $error("direct physical address wrong");

    chk_uwe_store: assert property (@(posedge clk) disable iff (!rst_n)
        (req.valid && req.user_mode && req.is_store && !req.user_write_enable
         && sel != `VASD_SEG_DIRECT) |=> rsp.fault)
        else $error("user store without write enable did not fault");

    chk_mapped_seg: assert property (@(posedge clk) disable iff (!rst_n)
        (req.valid && canonical && sel[1] == 1'b0)
        |=> (rsp.seg == low_mapped_segment && rsp.translate))
        else $error("low mapped segment not selected");

    chk_high_seg: assert property (@(posedge clk) disable iff (!rst_n)
        (req.valid && canonical && sel == `VASD_SEG_HIGH)
        |=> (rsp.seg == high_mapped_segment && rsp.translate))
        else $error("high mapped segment not selected");

    chk_offset_field: assert property (@(posedge clk) disable iff (!rst_n)
        req.valid |=> rsp.page_offset == 16'($past(req.va) & ((64'h1 << PAGE_SHIFT) - 1)))
        else $error("page offset wrong");

    chk_level_field: assert property (@(posedge clk) disable iff (!rst_n)
        req.valid |=> rsp.first_level_index
            == 16'(($past(req.va) >> (PAGE_SHIFT + 2 * LEVEL_BITS))
                   & ((64'h1 << LEVEL_BITS) - 1)))
        else $error("first level index wrong");

    chk_pa_width: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |-> (rsp.phys_addr >> PA_WIDTH) == 64'h0)
        else $error("physical address exceeds width");

    chk_reset_clear: assert property (@(posedge clk)
        !rst_n |=> rsp == '0)
        else $error("response not cleared by reset");

    chk_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        !req.valid |=> (!rsp.valid && !rsp.fault && !rsp.translate))
        else $error("idle cycle produced a response");

    chk_valid_follow: assert property (@(posedge clk) disable iff (!rst_n)
        req.valid |=> rsp.valid)
        else $error("request produced no response");

    chk_fault_valid: assert property (@(posedge clk) disable iff (!rst_n)
        rsp.fault |-> rsp.valid)
        else $error("fault without a request");

    chk_second_index: assert property (@(posedge clk) disable iff (!rst_n)
        req.valid |=> rsp.second_level_index
            == 16'(($past(req.va) >> (PAGE_SHIFT + LEVEL_BITS))
                   & ((64'h1 << LEVEL_BITS) - 1)))
        else $error("second level index wrong");

    chk_third_index: assert property (@(posedge clk) disable iff (!rst_n)
        req.valid |=> rsp.third_level_index
            == 16'(($past(req.va) >> PAGE_SHIFT) & ((64'h1 << LEVEL_BITS) - 1)))
        else $error("third level index wrong");

    chk_mapped_no_pa: assert property (@(posedge clk) disable iff (!rst_n)
        (req.valid && sel != `VASD_SEG_DIRECT) |=> rsp.phys_addr == 64'h0)
        else $error("mapped address gave a direct physical address");

    chk_kernel_map_ok: assert property (@(posedge clk) disable iff (!rst_n)
        (req.valid && canonical && !req.user_mode && sel != `VASD_SEG_DIRECT)
        |=> !rsp.fault)
        else $error("kernel access to mapped segment faulted");

    chk_user_store_ok: assert property (@(posedge clk) disable iff (!rst_n)
        (req.valid && canonical && req.user_mode && req.user_write_enable
         && sel != `VASD_SEG_DIRECT) |=> !rsp.fault)
        else $error("permitted user access faulted");

    chk_noncanon_seg: assert property (@(posedge clk) disable iff (!rst_n)
        (req.valid && !canonical && sel == `VASD_SEG_DIRECT)
        |=> rsp.seg == kernel_direct_segment)
        else $error("select bits ignored on a bad address");

    chk_direct_select: assert property (@(posedge clk) disable iff (!rst_n)
        (req.valid && sel == `VASD_SEG_DIRECT) |=> rsp.seg == kernel_direct_segment)
        else $error("direct select not decoded");

    chk_translate_mapped: assert property (@(posedge clk) disable iff (!rst_n)
        rsp.translate |-> rsp.seg != kernel_direct_segment)
        else $error("direct segment sent for translation");
endmodule : vasd_decode

// ==== vasd_agen_model.sv ====
`timescale 1ns/10ps
module vasd_agen_model
    import vasd_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire vasd_req_type nxt,
    output vasd_req_type      req
);
    // Registered issue like a real address stage, so requests land off the edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req <= '0;
        end else begin
            req <= nxt;
        end
    end
endmodule : vasd_agen_model

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top
    import vasd_pkg::*;
;
    localparam int PS  = 13;
    localparam int LVL = PS - 3;
    localparam int VW  = PS + 3 * LVL;
    logic         clk         = 1'h0;
    logic         rst_n       = 1'h0;
    vasd_req_type nxt         = '0;
    vasd_req_type req;
    vasd_rsp_type rsp;
    int           err_count   = 0;
    int           checks_done = 0;
    always #5 clk = ~clk;
    vasd_agen_model i_agen (.clk(clk), .rst_n(rst_n), .nxt(nxt), .req(req));
    vasd_decode #(.PAGE_SHIFT(PS)) i_dut (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp));
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Two edges of latency: one in the model, one in the decoder
    task automatic issue(input logic [63:0] va, input logic [3:0] ctl);
        @(posedge clk);
        nxt <= '{1'h1, va, ctl[3], ctl[2], ctl[1], ctl[0]};
        repeat (2) @(posedge clk);
        #1;
    endtask : issue
    task automatic check_rsp(input logic f, input logic [1:0] s, input logic t, input logic [63:0] pa);
        check("valid", {63'h0, rsp.valid}, 64'h0000_0000_0000_0001);
        check("fault", {63'h0, rsp.fault}, {63'h0, f});
        check("seg", {62'h0, rsp.seg}, {62'h0, s});
        check("translate", {63'h0, rsp.translate}, {63'h0, t});
        // Address contents are not defined once a fault is flagged
        if (!f) check("phys", rsp.phys_addr, pa);
    endtask : check_rsp
    task automatic t_direct();
        issue(64'hFFFF_FC00_0000_1234, 4'h0);
        check_rsp(1'h0, 2'h3, 1'h0, 64'h0000_0000_0000_1234);
        issue(64'hFFFF_FD00_0000_0000, 4'h4);
        check_rsp(1'h0, 2'h3, 1'h0, 64'h0000_0100_0000_0000);
        issue(64'hFFFF_FC00_0000_1234, 4'h8);
        check_rsp(1'h1, 2'h3, 1'h0, 64'h0);
        issue(64'hFFFF_FC00_0000_0040, 4'hD);
        check_rsp(1'h1, 2'h3, 1'h0, 64'h0);
        $display("test direct done");
    endtask : t_direct
    task automatic t_noncanon();
        issue(64'h0000_0400_0000_0000, 4'h0);
        check_rsp(1'h1, 2'h3, 1'h0, 64'h0);
        issue(64'hFFFF_F800_0000_0000, 4'h0);
        check_rsp(1'h1, 2'h0, 1'h0, 64'h0);
        issue(64'h0000_0800_0000_0000, 4'h0);
        check_rsp(1'h1, 2'h0, 1'h0, 64'h0);
        $display("test noncanonical done");
    endtask : t_noncanon
    task automatic t_mapped();
        logic [63:0] va [3] = '{64'hFFFF_FEAB_CDEF_1357, 64'h0000_0123_4567_89AB,
                                64'h0000_0034_5678_9ABC};
        logic [1:0]  sg [3] = '{2'h1, 2'h0, 2'h0};
        for (int i = 0; i < 3; i++) begin
            issue(va[i], 4'hD);
            check_rsp(1'h0, sg[i], 1'h1, 64'h0);
            check("l1", {54'h0, rsp.first_level_index[LVL-1:0]}, {54'h0, va[i][VW-1 -: LVL]});
            check("l2", {54'h0, rsp.second_level_index[LVL-1:0]}, {54'h0, va[i][VW-LVL-1 -: LVL]});
            check("l3", {54'h0, rsp.third_level_index[LVL-1:0]}, {54'h0, va[i][PS+LVL-1 -: LVL]});
            check("off", {51'h0, rsp.page_offset[PS-1:0]}, {51'h0, va[i][PS-1:0]});
        end
        $display("test mapped done");
    endtask : t_mapped
    task automatic t_uwe();
        // Control nibble: user, store, pte valid, user write enable
        logic [3:0] ctl [5] = '{4'hC, 4'hE, 4'h8, 4'h4, 4'hD};
        logic       flt [5] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0};
        for (int i = 0; i < 5; i++) begin
            issue(64'h0000_0000_0000_2000, ctl[i]);
            check_rsp(flt[i], 2'h0, 1'h1, 64'h0);
        end
        $display("test write enable done");
    endtask : t_uwe
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #20000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (15) @(posedge clk);
        #1;
        check("reset rsp", {63'h0, |rsp}, 64'h0);
        $display("test reset done");
        @(posedge clk);
        rst_n <= 1'h1;
        t_direct();
        t_noncanon();
        t_mapped();
        t_uwe();
        tally_and_finish();
    end
endmodule : tb_top
